// File: hw/ccd_regs.svh
// register offsets, field positions, reset values and address bounds
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

`define CCD_IDX_CTRL 16'h0000
`define CCD_IDX_STAT 16'h0001
`define CCD_IDX_CFG0 16'h2018
`define CCD_IDX_CFG1 16'h201a
`define CCD_IDX_CFG2 16'h201c

`define CCD_CFG_RST 8'hff
`define CCD_CTRL_RST 1'b1
`define CCD_STAT_SEEN 16

`define CCD_B0_WD0 1
`define CCD_B0_RDY0 4
`define CCD_B0_RDY1 5
`define CCD_B0_PRT0 6
`define CCD_B0_PRT1 7
`define CCD_B1_WD1 0
`define CCD_B1_RDY2 1
`define CCD_B1_TMS0 4
`define CCD_B1_TMS1 5
`define CCD_B2_ZERO 0
`define CCD_B2_A24 1
`define CCD_B2_SEGA 2

`define CCD_EPROM_LO 16'h2080
`define CCD_EPROM_HI 16'h9fff
`define CCD_RSVD_LO 16'h2000
`define CCD_RSVD_HI 16'h207f
`define CCD_MSFR_LO 16'h1fe0
`define CCD_MSFR_HI 16'h1fff
`define CCD_PSFR_LO 16'h1f00
`define CCD_PSFR_HI 16'h1fdf
`define CCD_CAN_LO 16'h1e00
`define CCD_CAN_HI 16'h1eff
`define CCD_CRAM_LO 16'h0400
`define CCD_CRAM_HI 16'h04ff
`define CCD_UREG_LO 16'h0100
`define CCD_UREG_HI 16'h03ff
`define CCD_LREG_LO 16'h0018
`define CCD_LREG_HI 16'h00ff
`define CCD_CSFR_HI 16'h0017
`define CCD_FETCH_HI 16'h03ff
`define CCD_SEG_LOW 8'h00
`define CCD_SEG_HIGH 8'hff

`define CCD_RESP_OKAY 2'b00
`define CCD_RESP_SLVERR 2'b10

`endif

// File: hw/ccd_pkg.sv
// types shared by the decode logic, the top level and the bench
package ccd_pkg;
    typedef enum logic [9:0] {
        RG_EXT = 10'b00_0000_0001,
        RG_EPROM = 10'b00_0000_0010,
        RG_RSVD = 10'b00_0000_0100,
        RG_MSFR = 10'b00_0000_1000,
        RG_PSFR = 10'b00_0001_0000,
        RG_CAN = 10'b00_0010_0000,
        RG_CRAM = 10'b00_0100_0000,
        RG_UREG = 10'b00_1000_0000,
        RG_LREG = 10'b01_0000_0000,
        RG_CSFR = 10'b10_0000_0000
    } ccd_region_t;
endpackage : ccd_pkg

// File: hw/ccd_decode.sv
// address decoder: one access address to one region
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"
module ccd_decode import ccd_pkg::*; #(
    parameter bit LARGE = 1'b0
) (
    input wire logic [23:0] addr,
    input wire logic fetch,
    input wire logic addr_24bit,
    input wire logic segment_a,
    input wire logic ext_access_n,
    output ccd_region_t region
);
    logic [7:0] seg;
    logic [15:0] a;
    logic seg0;
    logic int_seg;

    always_comb begin
        seg = addr_24bit ? addr[23:16] : `CCD_SEG_LOW;
        a = addr[15:0];
        seg0 = (seg == `CCD_SEG_LOW);
        // large part: memories in the top segment, low one only remapped
        int_seg = LARGE ? ((seg == `CCD_SEG_HIGH) || (segment_a && seg0))
                        : seg0;
        region = RG_EXT;
        if (int_seg && a >= `CCD_EPROM_LO && a <= `CCD_EPROM_HI) begin
            region = RG_EPROM;
        end else if (int_seg && a >= `CCD_RSVD_LO
                     && a <= `CCD_RSVD_HI) begin
            region = ext_access_n ? RG_RSVD : RG_EXT;
        end else if (int_seg && a >= `CCD_CRAM_LO
                     && a <= `CCD_CRAM_HI) begin
            region = RG_CRAM;
        end else if (seg0) begin
            if (a >= `CCD_MSFR_LO && a <= `CCD_MSFR_HI) begin
                region = RG_MSFR;
            end else if (a >= `CCD_PSFR_LO && a <= `CCD_PSFR_HI) begin
                region = RG_PSFR;
            end else if (a >= `CCD_CAN_LO && a <= `CCD_CAN_HI) begin
                region = RG_CAN;
            end else if (a >= `CCD_UREG_LO && a <= `CCD_UREG_HI) begin
                region = RG_UREG;
            end else if (a >= `CCD_LREG_LO && a <= `CCD_LREG_HI) begin
                region = RG_LREG;
            end else if (a <= `CCD_CSFR_HI) begin
                region = RG_CSFR;
            end
        end
        // code below 0400h never runs from the register files
        if (fetch && seg0 && a <= `CCD_FETCH_HI) begin
            region = RG_EXT;
        end
    end
endmodule : ccd_decode
`default_nettype wire

// File: hw/ccd_cfg.sv
// field decode of the three configuration bytes
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"
module ccd_cfg #(
    parameter bit LARGE = 1'b0
) (
    input wire logic [7:0] b0,
    input wire logic [7:0] b1,
    input wire logic [7:0] b2,
    output logic rd_block,
    output logic wr_block,
    output logic auto_wait,
    output logic [1:0] ready_limit,
    output logic ready_unlimited,
    output logic bw_pin_ctl,
    output logic addr_24bit,
    output logic segment_a,
    output logic illegal
);
    logic [1:0] loc;
    logic [1:0] msel;
    logic [2:0] irc;
    logic [1:0] bw;

    always_comb begin
        loc = {b0[`CCD_B0_PRT1], b0[`CCD_B0_PRT0]};
        msel = {b1[`CCD_B1_TMS1], b1[`CCD_B1_TMS0]};
        irc = {b1[`CCD_B1_RDY2], b0[`CCD_B0_RDY1], b0[`CCD_B0_RDY0]};
        bw = {b1[`CCD_B1_WD1], b0[`CCD_B0_WD0]};
        rd_block = !loc[0];
        wr_block = !loc[1];
        // reserved timing codes fall back to the slower, safe mode 0
        auto_wait = (msel != 2'b11);
        ready_limit = 2'b00;
        ready_unlimited = 1'b0;
        case (irc)
            3'b100: ready_limit = 2'd1;
            3'b101: ready_limit = 2'd2;
            3'b110: ready_limit = 2'd3;
            3'b111: ready_unlimited = 1'b1;
            default: ready_limit = 2'd0;
        endcase
        bw_pin_ctl = bw[1];
        addr_24bit = LARGE && b2[`CCD_B2_A24];
        segment_a = LARGE && b2[`CCD_B2_SEGA];
        illegal = (bw == 2'b00) || (msel == 2'b01) || (msel == 2'b10)
            || (LARGE && (b2[`CCD_B2_ZERO] || b2[7:3] != 5'h1f));
    end
endmodule : ccd_cfg
`default_nettype wire

// File: hw/ccd_top.sv
// configuration bytes, memory decode and register slave
// Contract
// - 2080h-9FFFh decodes to the internal program memory.
// - 2000h-207Fh goes internal or external per the access pin.
// - 1FE0h-1FFFh is the memory-mapped special register space.
// - 1F00h-1FDFh is the peripheral special register space.
// - 1E00h-1EFFh is the CAN peripheral memory.
// - 0400h-04FFh is code RAM, indirect or indexed only.
// - 0100h-03FFh is the upper register file.
// - 0018h-00FFh is the lower register file.
// - 0000h-0017h are the CPU special registers.
// - instruction fetches below 0400h always go to the external bus.
// - the third configuration byte exists only on the larger part.
// - third byte bit 1 picks 16-bit or 24-bit addressing.
// - segment_a bit places memories in segment FFh, or also 00h.
// - lock bits: 00 no access, 01 no write, 10 no read, 11 free.
// - timing code 00 is mode 0, 11 mode 3, others reserved.
// - mode 0 adds one wait state to each external cycle.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"
module ccd_top import ccd_pkg::*; #(
    parameter bit LARGE = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cfg_load,
    input wire logic [15:0] cfg_addr,
    input wire logic [7:0] cfg_data,
    input wire logic cpu_req,
    input wire logic [23:0] cpu_addr,
    input wire logic cpu_write,
    input wire logic cpu_fetch,
    input wire logic external_access_pin_n,
    input wire logic bus_width_pin,
    output logic route_valid,
    output ccd_region_t route_region,
    output logic route_ext,
    output logic route_blocked,
    output logic bus_16bit,
    output logic auto_wait,
    output logic [1:0] ready_limit,
    output logic ready_unlimited,
    output logic addr_24bit,
    output logic cfg_illegal
);
    // byte address is four times the index; no index reaches bit 14
    localparam logic [15:0] ADDR_CTRL = `CCD_IDX_CTRL << 2;
    localparam logic [15:0] ADDR_STAT = `CCD_IDX_STAT << 2;
    localparam logic [15:0] ADDR_CFG0 = `CCD_IDX_CFG0 << 2;
    localparam logic [15:0] ADDR_CFG1 = `CCD_IDX_CFG1 << 2;
    localparam logic [15:0] ADDR_CFG2 = `CCD_IDX_CFG2 << 2;

    logic [7:0] cfg0, cfg1, cfg2;
    logic [7:0] next_cfg0, next_cfg1, next_cfg2;
    logic protect_en, next_protect_en;
    logic seen, next_seen;
    logic aw_hold, next_aw_hold, w_hold, next_w_hold;
    logic [15:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic r_valid, next_r_valid, r_ext, next_r_ext;
    logic r_blk, next_r_blk, r_b16, next_r_b16;
    ccd_region_t r_region, next_r_region, dec_region;
    logic rd_block, wr_block, bw_pin_ctl, segment_a;
    logic aw_take, w_take, aw_got, w_got, do_write, ar_take;
    logic eprom_hit, blk_now;
    logic [31:0] stat_word;

    ccd_cfg #(.LARGE(LARGE)) u_cfg (
        .b0(cfg0),
        .b1(cfg1),
        .b2(cfg2),
        .rd_block(rd_block),
        .wr_block(wr_block),
        .auto_wait(auto_wait),
        .ready_limit(ready_limit),
        .ready_unlimited(ready_unlimited),
        .bw_pin_ctl(bw_pin_ctl),
        .addr_24bit(addr_24bit),
        .segment_a(segment_a),
        .illegal(cfg_illegal)
    );

    ccd_decode #(.LARGE(LARGE)) u_dec (
        .addr(cpu_addr),
        .fetch(cpu_fetch),
        .addr_24bit(addr_24bit),
        .segment_a(segment_a),
        .ext_access_n(external_access_pin_n),
        .region(dec_region)
    );

    // configuration bytes are captured as the loader reads reserved memory
    always_comb begin
        next_cfg0 = cfg0;
        next_cfg1 = cfg1;
        next_cfg2 = cfg2;
        if (cfg_load && cfg_addr == `CCD_IDX_CFG0) begin
            next_cfg0 = cfg_data;
        end
        if (cfg_load && cfg_addr == `CCD_IDX_CFG1) begin
            next_cfg1 = cfg_data;
        end
        if (cfg_load && cfg_addr == `CCD_IDX_CFG2 && LARGE) begin
            next_cfg2 = cfg_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg0 <= `CCD_CFG_RST;
            cfg1 <= `CCD_CFG_RST;
            cfg2 <= LARGE ? `CCD_CFG_RST : 8'h00;
        end else begin
            cfg0 <= next_cfg0;
            cfg1 <= next_cfg1;
            cfg2 <= next_cfg2;
        end
    end

    // access routing, one cycle behind the request
    always_comb begin
        eprom_hit = (dec_region == RG_EPROM) || (dec_region == RG_RSVD);
        blk_now = cpu_req && protect_en && eprom_hit && !cpu_fetch
            && (cpu_write ? wr_block : rd_block);
        next_r_valid = cpu_req;
        next_r_region = cpu_req ? dec_region : r_region;
        next_r_ext = cpu_req && (dec_region == RG_EXT);
        next_r_blk = blk_now;
        next_r_b16 = bw_pin_ctl ? bus_width_pin : 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_valid <= 1'b0;
            r_region <= RG_EXT;
            r_ext <= 1'b0;
            r_blk <= 1'b0;
            r_b16 <= 1'b1;
        end else begin
            r_valid <= next_r_valid;
            r_region <= next_r_region;
            r_ext <= next_r_ext;
            r_blk <= next_r_blk;
            r_b16 <= next_r_b16;
        end
    end

    assign route_valid = r_valid;
    assign route_region = r_region;
    assign route_ext = r_ext;
    assign route_blocked = r_blk;
    assign bus_16bit = r_b16;

    // register slave: address and data taken in either order
    assign s_axi_awready = !aw_hold && !bvalid;
    assign s_axi_wready = !w_hold && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;

    always_comb begin
        aw_take = s_axi_awvalid && s_axi_awready;
        w_take = s_axi_wvalid && s_axi_wready;
        aw_got = aw_hold || aw_take;
        w_got = w_hold || w_take;
        do_write = aw_got && w_got;
        ar_take = s_axi_arvalid && s_axi_arready;
        stat_word = 32'h0000_0000;
        stat_word[9:0] = r_region;
        stat_word[10] = cfg_illegal;
        stat_word[`CCD_STAT_SEEN] = seen;
        next_aw_hold = aw_got && !do_write;
        next_w_hold = w_got && !do_write;
        next_aw_addr = aw_take ? s_axi_awaddr : aw_addr;
        next_w_data = w_take ? s_axi_wdata : w_data;
        next_w_strb = w_take ? s_axi_wstrb : w_strb;
        next_bvalid = bvalid && !s_axi_bready;
        next_bresp = bresp;
        next_protect_en = protect_en;
        // a new violation beats a clear in the same cycle
        next_seen = seen || r_blk;
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp = `CCD_RESP_OKAY;
            // data from the current beat if it arrives with the address
            if (aw_take ? s_axi_awaddr == ADDR_CTRL
                        : aw_addr == ADDR_CTRL) begin
                if (w_take ? s_axi_wstrb[0] : w_strb[0]) begin
                    next_protect_en = w_take ? s_axi_wdata[0] : w_data[0];
                end
            end else if (aw_take ? s_axi_awaddr == ADDR_STAT
                                 : aw_addr == ADDR_STAT) begin
                if ((w_take ? s_axi_wstrb[2] : w_strb[2])
                    && (w_take ? s_axi_wdata[`CCD_STAT_SEEN]
                               : w_data[`CCD_STAT_SEEN])) begin
                    next_seen = r_blk;
                end
            end else begin
                // configuration bytes are read-only; the rest unmapped
                next_bresp = `CCD_RESP_SLVERR;
            end
        end
        next_rvalid = rvalid && !s_axi_rready;
        next_rdata = rdata;
        next_rresp = rresp;
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp = `CCD_RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL: next_rdata = {31'h0000_0000, protect_en};
                ADDR_STAT: next_rdata = stat_word;
                ADDR_CFG0: next_rdata = {24'h00_0000, cfg0};
                ADDR_CFG1: next_rdata = {24'h00_0000, cfg1};
                ADDR_CFG2: next_rdata = {24'h00_0000, cfg2};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `CCD_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 16'h0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `CCD_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `CCD_RESP_OKAY;
            rdata <= 32'h0000_0000;
            protect_en <= `CCD_CTRL_RST;
            seen <= 1'b0;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            protect_en <= next_protect_en;
            seen <= next_seen;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_eprom_map:
    assert property (cpu_req && !addr_24bit
        && cpu_addr[15:0] >= `CCD_EPROM_LO
        && cpu_addr[15:0] <= `CCD_EPROM_HI && !LARGE
        |=> route_region == RG_EPROM)
        else $error("program memory range misrouted");
    a_rsvd_pin:
    assert property (cpu_req && !LARGE && !external_access_pin_n
        && cpu_addr[15:0] >= `CCD_RSVD_LO
        && cpu_addr[15:0] <= `CCD_RSVD_HI |=> route_ext)
        else $error("reserved range ignored access pin");
    a_cpu_sfr:
    assert property (cpu_req && !cpu_fetch && !addr_24bit
        && cpu_addr[15:0] <= `CCD_CSFR_HI |=> route_region == RG_CSFR)
        else $error("cpu register range misrouted");
    a_lower_file:
    assert property (cpu_req && !cpu_fetch && !addr_24bit
        && cpu_addr[15:0] >= `CCD_LREG_LO
        && cpu_addr[15:0] <= `CCD_LREG_HI |=> route_region == RG_LREG)
        else $error("lower file misrouted");
    a_fetch_forced:
    assert property (cpu_req && cpu_fetch && !addr_24bit
        && cpu_addr[15:0] <= `CCD_FETCH_HI |=> route_valid && route_ext)
        else $error("low fetch stayed internal");
    a_write_lock:
    assert property (cpu_req && cpu_write && !cpu_fetch && protect_en
        && !cfg0[`CCD_B0_PRT1] && dec_region == RG_EPROM
        |=> route_blocked)
        else $error("locked write not blocked");
    a_mode0_wait:
    assert property (!cfg1[`CCD_B1_TMS1] && !cfg1[`CCD_B1_TMS0]
        |-> auto_wait)
        else $error("mode 0 lacks wait state");
    a_ready_cap:
    assert property ({cfg1[`CCD_B1_RDY2], cfg0[`CCD_B0_RDY1],
        cfg0[`CCD_B0_RDY0]} == 3'b101 |-> ready_limit == 2'd2
        && !ready_unlimited)
        else $error("ready limit wrong");
    a_width_fixed:
    assert property (cpu_req && !cfg1[`CCD_B1_WD1] |=> bus_16bit)
        else $error("fixed width not 16-bit");
    a_write_resp:
    assert property (s_axi_awvalid && s_axi_wvalid && !aw_hold && !w_hold
        && !bvalid |=> bvalid)
        else $error("write response late");

    c_ext_access: cover property (cpu_req ##1 route_ext);
    c_blocked: cover property (route_blocked);
    c_reg_read: cover property (ar_take ##1 rvalid && s_axi_rready);
endmodule : ccd_top
`default_nettype wire

// File: testbench/ccd_cfg_mem.sv
// partner model: configuration memory handing one byte per request
`timescale 1ns/1ps
`default_nettype none
module ccd_cfg_mem (
    input wire logic aclk,
    input wire logic go,
    input wire logic [1:0] sel,
    input wire logic [7:0] val,
    output logic cfg_load,
    output logic [15:0] cfg_addr,
    output logic [7:0] cfg_data
);
    logic [15:0] junk = 16'h5a5a;
    always @(posedge aclk) begin
        junk <= ~junk;
        cfg_load <= go;
        if (go) begin
            // bytes sit on even addresses from the first config byte up
            cfg_addr <= 16'h2018 + {13'h0000, sel, 1'b0};
            // third byte image keeps its fixed reserved bits
            cfg_data <= (sel == 2'h2) ? {5'h1f, val[2:1], 1'b0} : val;
        end else begin
            // lines outside a load carry a changing pattern
            cfg_addr <= junk;
            cfg_data <= junk[7:0];
        end
    end
endmodule : ccd_cfg_mem
`default_nettype wire

// File: testbench/test_chip_config_memory_decode.sv
// self-checking bench for the configuration and memory decode block
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"
module test_chip_config_memory_decode import ccd_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cpu_req = 1'b0, cpu_write = 1'b0, cpu_fetch = 1'b0;
    logic [23:0] cpu_addr = 24'h00_0000;
    logic pin_n = 1'b1, bw_pin = 1'b0, go = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [7:0] val = 8'h00;
    logic cfg_load, route_valid, route_ext, route_blocked, bus_16bit;
    logic [15:0] cfg_addr;
    logic [7:0] cfg_data;
    ccd_region_t route_region;
    logic [1:0] ready_limit;
    logic auto_wait, ready_unlimited, addr_24bit, cfg_illegal;
    logic [33:0] qa[$];
    logic [33:0] qd[$];
    int mismatches = 0, n_compared = 0, seed = 66296;

    always #12.5 aclk = ~aclk;

    ccd_cfg_mem pm_u (.aclk(aclk), .go(go), .sel(sel), .val(val),
        .cfg_load(cfg_load), .cfg_addr(cfg_addr), .cfg_data(cfg_data));
    ccd_top #(.LARGE(1'b0)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cfg_load(cfg_load), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
        .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
        .cpu_fetch(cpu_fetch), .external_access_pin_n(pin_n),
        .bus_width_pin(bw_pin), .route_valid(route_valid),
        .route_region(route_region), .route_ext(route_ext),
        .route_blocked(route_blocked), .bus_16bit(bus_16bit),
        .auto_wait(auto_wait), .ready_limit(ready_limit),
        .ready_unlimited(ready_unlimited), .addr_24bit(addr_24bit),
        .cfg_illegal(cfg_illegal));

    task automatic bad(input string m);
        mismatches++;
        $display("BAD t=%0t %s", $time, m);
    endtask : bad

    task automatic chk(input logic [33:0] g, input logic [33:0] e,
                       input string m);
        n_compared++;
        if (g !== e) begin
            bad(m);
        end
    endtask : chk

    // results are matched against the oldest note when they appear
    always @(posedge aclk) begin
        if (route_valid === 1'b1) begin
            chk({22'h00_0000, route_blocked, route_ext, route_region},
                qd.pop_front(), "route");
        end
        if ((bvalid && bready) === 1'b1) begin
            chk({bresp, 32'h0000_0000}, qa.pop_front(), "bresp");
        end
        if ((rvalid && rready) === 1'b1) begin
            chk({rresp, rdata}, qa.pop_front(), "rdata");
        end
    end

    task automatic axi(input bit wr, input logic [15:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        bit ta, tw, tr, da, dw;
        int n;
        qa.push_back(e);
        da = 1'b0;
        dw = !wr;
        tr = 1'b0;
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        // readies are looked at mid-cycle, acted on at the next edge
        for (n = 0; n < 100 && !tr; n++) begin
            @(negedge aclk);
            ta = wr ? awvalid && awready : arvalid && arready;
            tw = wvalid && wready;
            tr = (wr ? bvalid : rvalid) && da && dw;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
                da = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                dw = 1'b1;
            end
            if (tr) begin
                bready <= 1'b0;
                rready <= 1'b0;
            end
        end
        // one edge apart, so a following call never re-drives the readies
        @(posedge aclk);
        if (!tr) begin
            bad("bus hang");
            print_verdict();
        end
    endtask : axi

    task automatic ld(input logic [1:0] s, input logic [7:0] v);
        sel <= s;
        val <= v;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : ld

    // leaves the request up so calls in a row go back to back
    task automatic dec(input logic [23:0] a, input bit f, input bit w,
                       input ccd_region_t r, input bit b);
        qd.push_back({22'h00_0000, b, r == RG_EXT, r});
        cpu_addr <= a;
        cpu_fetch <= f;
        cpu_write <= w;
        cpu_req <= 1'b1;
        @(posedge aclk);
    endtask : dec

    task automatic idle;
        cpu_req <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : idle

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge aclk);
        bad("timeout");
        print_verdict();
    end

    initial begin
        logic [23:0] at[21] = '{24'h00_2080, 24'h00_9fff, 24'h00_a000,
            24'h00_2000, 24'h00_207f, 24'h00_1fe0, 24'h00_1fff, 24'h00_1f00,
            24'h00_1fdf, 24'h00_1e00, 24'h00_1eff, 24'h00_1dff, 24'h00_0500,
            24'h00_0400, 24'h00_04ff, 24'h00_0100, 24'h00_03ff, 24'h00_0018,
            24'h00_00ff, 24'h00_0017, 24'h00_0000};
        ccd_region_t rt[21] = '{RG_EPROM, RG_EPROM, RG_EXT, RG_RSVD,
            RG_RSVD, RG_MSFR, RG_MSFR, RG_PSFR, RG_PSFR, RG_CAN, RG_CAN,
            RG_EXT, RG_EXT, RG_CRAM, RG_CRAM, RG_UREG, RG_UREG, RG_LREG,
            RG_LREG, RG_CSFR, RG_CSFR};
        logic [2:0] rc[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi(0, 16'h0000, 0, {`CCD_RESP_OKAY, 32'h0000_0001});
        axi(0, 16'h8060, 0, {`CCD_RESP_OKAY, 32'h0000_00ff});
        axi(0, 16'h8070, 0, {`CCD_RESP_OKAY, 32'h0000_0000});
        axi(0, 16'h0010, 0, {`CCD_RESP_SLVERR, 32'h0000_0000});
        axi(1, 16'h8060, $random(seed), {`CCD_RESP_SLVERR, 32'h0000_0000});
        axi(0, 16'h8060, 0, {`CCD_RESP_OKAY, 32'h0000_00ff});
        for (int i = 0; i < 21; i++) begin
            dec(at[i], 1'b0, i[0], rt[i], 1'b0);
        end
        dec(24'h00_0000, 1'b1, 1'b0, RG_EXT, 1'b0);
        dec(24'h00_03ff, 1'b1, 1'b0, RG_EXT, 1'b0);
        dec(24'h00_0400, 1'b1, 1'b0, RG_CRAM, 1'b0);
        pin_n <= 1'b0;
        dec(24'h00_2000, 1'b0, 1'b0, RG_EXT, 1'b0);
        pin_n <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            dec(24'h00_a000 + 24'($unsigned($random(seed)) % 24'h00_6000),
                1'b0, 1'($random(seed)), RG_EXT, 1'b0);
        end
        idle();
        for (int k = 0; k < 4; k++) begin
            ld(2'h0, {k[1:0], 6'h3f});
            axi(0, 16'h8060, 0, {`CCD_RESP_OKAY, 24'h00_0000, k[1:0], 6'h3f});
            dec(24'h00_3000, 1'b0, 1'b0, RG_EPROM, !k[0]);
            dec(24'h00_3000, 1'b0, 1'b1, RG_EPROM, !k[1]);
            dec(24'h00_2010, 1'b0, 1'b0, RG_RSVD, !k[0]);
            dec(24'h00_3000, 1'b1, 1'b0, RG_EPROM, 1'b0);
            idle();
        end
        ld(2'h0, 8'h3f);
        axi(1, 16'h0000, 32'h0000_0000, {`CCD_RESP_OKAY, 32'h0});
        dec(24'h00_3000, 1'b0, 1'b0, RG_EPROM, 1'b0);
        idle();
        axi(1, 16'h0000, 32'h0000_0001, {`CCD_RESP_OKAY, 32'h0});
        dec(24'h00_3000, 1'b0, 1'b0, RG_EPROM, 1'b1);
        idle();
        axi(0, 16'h0004, 0, {`CCD_RESP_OKAY, 32'h0001_0002});
        axi(1, 16'h0004, 32'h0001_0000, {`CCD_RESP_OKAY, 32'h0});
        axi(0, 16'h0004, 0, {`CCD_RESP_OKAY, 32'h0000_0002});
        for (int m = 0; m < 4; m++) begin
            ld(2'h1, 8'hcf | {2'h0, m[1:0], 4'h0});
            chk({32'h0, auto_wait, cfg_illegal},
                {32'h0, m != 3, m == 1 || m == 2}, "timing");
        end
        for (int c = 0; c < 5; c++) begin
            ld(2'h0, {2'h3, rc[c][1:0], 4'hf});
            ld(2'h1, {6'h3f, rc[c][2], 1'b1});
            chk({31'h0, ready_unlimited, c == 4 ? 2'h0 : ready_limit},
                {31'h0, c == 4, c == 4 ? 2'h0 : 2'(c)}, "ready");
        end
        for (int b = 0; b < 8; b++) begin
            bw_pin <= b[2];
            ld(2'h0, {6'h3f, b[0], 1'b1});
            ld(2'h1, {7'h7f, b[1]});
            dec(24'h00_a000, 1'b0, 1'b0, RG_EXT, 1'b0);
            idle();
            chk({32'h0, bus_16bit, cfg_illegal},
                {32'h0, b[1] ? b[2] : 1'b1, b[1:0] == 0}, "width");
        end
        ld(2'h2, 8'hff);
        chk({33'h0, addr_24bit}, 34'h0, "addr width");
        axi(0, 16'h8070, 0, {`CCD_RESP_OKAY, 32'h0000_0000});
        repeat (4) @(posedge aclk);
        chk(34'(qd.size() + qa.size()), 34'h0, "missing results");
        print_verdict();
    end
endmodule : test_chip_config_memory_decode
`default_nettype wire
